// [interrupt_routing_offset_trim_tb_top.sv]
`timescale 1ns/1ps
module interrupt_routing_offset_trim_tb_top;
  import irt_pkg::*;
  logic               i_mclk = 1'b0;
  logic               i_reset_n = 1'b0;
  irt_reg_req_s       req = '0;
  logic [7:0]         rdata;
  logic [7:0]         flags = 8'h00;
  logic               sleep = 1'b0;
  logic               wake;
  logic signed [15:0] xs = 16'sd100;
  logic signed [15:0] xo, yo, zo;
  logic               a_out, a_oe, b_out, b_oe;
  logic               pol = 1'b0;
  logic               line_a, line_b, irq_a, irq_b;
  int                 num_errors = 0;
  int                 num_checks = 0;
  localparam logic [7:0] RST_ADDRS [6] = '{IRT_ADDR_WAKE_PIN, IRT_ADDR_ENABLE_MAP,
    IRT_ADDR_PIN_ROUTING, IRT_ADDR_X_TRIM, IRT_ADDR_Y_TRIM, IRT_ADDR_Z_TRIM};

  // clock generation
  always #2.5 i_mclk = ~i_mclk;

  irt_interrupt_routing_offset_trim dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_src_flags(flags), .i_sleep_mode(sleep), .o_wake_request(wake),
    .i_x_sample(xs), .i_y_sample(xs), .i_z_sample(xs),
    .o_x_sample(xo), .o_y_sample(yo), .o_z_sample(zo),
    .o_irq_pin_a_out(a_out), .o_irq_pin_a_oe(a_oe),
    .o_irq_pin_b_out(b_out), .o_irq_pin_b_oe(b_oe));

  irt_host_model host (
    .i_pin_a_out(a_out), .i_pin_a_oe(a_oe), .i_pin_b_out(b_out), .i_pin_b_oe(b_oe),
    .i_active_high(pol), .o_line_a(line_a), .o_line_b(line_b),
    .o_irq_a(irq_a), .o_irq_b(irq_b));

  // compare one value, zero extended
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one write strobe, held for one edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    #1 req = '0;
  endtask : reg_wr

  // one read strobe, data settled after the taking edge
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_mclk);
    #1 req = '0;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : reg_rd

  // let config and flags reach the registered pins
  task automatic settle;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : settle

  // expected host view of both pins
  task automatic pins(input logic ea, input logic eb);
    chk("irq_a", {15'h0, ea}, {15'h0, irq_a});
    chk("irq_b", {15'h0, eb}, {15'h0, irq_b});
  endtask : pins

  task automatic final_report;
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // watchdog
  initial begin
    #50000;
    num_errors++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    foreach (RST_ADDRS[i]) reg_rd(RST_ADDRS[i], 8'h00);
    pins(1'b0, 1'b0);
    chk("oe_a", 16'h0001, {15'h0, a_oe});
    reg_wr(IRT_ADDR_WAKE_PIN, 8'hff);
    reg_rd(IRT_ADDR_WAKE_PIN, 8'h7b);
    reg_wr(IRT_ADDR_WAKE_PIN, 8'h00);
    reg_wr(IRT_ADDR_PIN_ROUTING, 8'hff);
    reg_rd(IRT_ADDR_PIN_ROUTING, 8'hbd);
    reg_wr(IRT_ADDR_ENABLE_MAP, 8'hff);
    reg_rd(IRT_ADDR_ENABLE_MAP, 8'hbd);
    // each source routed to a, to b, then disabled
    for (int i = 0; i < 8; i++) begin
      if (IRT_SRC_MASK[i]) begin
        flags = 8'h01 << i;
        reg_rd(IRT_ADDR_SOURCE, 8'h01 << i);
        reg_wr(IRT_ADDR_PIN_ROUTING, 8'h01 << i);
        settle();
        pins(1'b1, 1'b0);
        reg_wr(IRT_ADDR_PIN_ROUTING, 8'h00);
        settle();
        pins(1'b0, 1'b1);
        reg_wr(IRT_ADDR_ENABLE_MAP, 8'hbd ^ (8'h01 << i));
        settle();
        pins(1'b0, 1'b0);
        reg_wr(IRT_ADDR_ENABLE_MAP, 8'hbd);
      end
    end
    // polarity and drive style on pin a, flagged sleep_wake source routed there
    reg_wr(IRT_ADDR_PIN_ROUTING, 8'h80);
    reg_wr(IRT_ADDR_WAKE_PIN, 8'h02);
    pol = 1'b1;
    settle();
    pins(1'b1, 1'b0);
    chk("line_a", 16'h0001, {15'h0, line_a});
    reg_wr(IRT_ADDR_WAKE_PIN, 8'h01);
    pol = 1'b0;
    settle();
    chk("oe_a", 16'h0001, {15'h0, a_oe});
    chk("line_a", 16'h0000, {15'h0, line_a});
    chk("oe_b", 16'h0000, {15'h0, b_oe});
    flags = 8'h00;
    settle();
    chk("oe_a", 16'h0000, {15'h0, a_oe});
    // each of the four wake functions wakes from sleep only when selected
    sleep = 1'b1;
    for (int i = 2; i < 6; i++) begin
      reg_wr(IRT_ADDR_WAKE_PIN, 8'h00);
      flags = 8'h01 << i;
      settle();
      chk("wake", 16'h0000, {15'h0, wake});
      pins(1'b0, 1'b0);
      reg_wr(IRT_ADDR_WAKE_PIN, 8'h02 << i);
      settle();
      chk("wake", 16'h0001, {15'h0, wake});
      pins(1'b0, 1'b1);
    end
    // sleep_wake and sample_ready pass in sleep but never wake
    reg_wr(IRT_ADDR_WAKE_PIN, 8'h00);
    flags = 8'h81;
    settle();
    pins(1'b1, 1'b1);
    chk("wake", 16'h0000, {15'h0, wake});
    sleep = 1'b0;
    flags = 8'h00;
    // trims: -1, +127 and -128 steps
    reg_wr(IRT_ADDR_X_TRIM, 8'hff);
    reg_wr(IRT_ADDR_Y_TRIM, 8'h7f);
    reg_wr(IRT_ADDR_Z_TRIM, 8'h80);
    settle();
    chk("x_out", 16'sd98, xo);
    chk("y_out", 16'sd354, yo);
    chk("z_out", -16'sd156, zo);
    reg_rd(IRT_ADDR_Y_TRIM, 8'h7f);
    reg_wr(8'h40, 8'h5a);
    reg_rd(8'h40, 8'h00);
    // source register is read-only
    reg_wr(IRT_ADDR_SOURCE, 8'hff);
    reg_rd(IRT_ADDR_SOURCE, 8'h00);
    // second reset in mid-run clears the trims
    i_reset_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    reg_rd(IRT_ADDR_Z_TRIM, 8'h00);
    chk("z_out", 16'sd100, zo);
    chk("oe_a", 16'h0001, {15'h0, a_oe});
    final_report();
  end
endmodule : interrupt_routing_offset_trim_tb_top

// [irt_axis_trim.sv]
`timescale 1ns/1ps
// adds a two's complement trim value to one axis sample
module irt_axis_trim #(
  parameter int AXIS_WIDTH = 16,
  parameter int TRIM_WIDTH = 8,
  parameter int STEP_MG    = 2
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset_n,
  input  wire logic signed [AXIS_WIDTH-1:0] i_sample,
  input  wire logic        [TRIM_WIDTH-1:0] i_trim,
  output      logic signed [AXIS_WIDTH-1:0] o_sample
);
  import irt_pkg::*;

  logic signed [AXIS_WIDTH-1:0] trim_mg;
  logic signed [AXIS_WIDTH-1:0] next_sample;

  // sign-extend, scale to mg, add
  always_comb begin
    trim_mg     = AXIS_WIDTH'(signed'(i_trim) * STEP_MG);
    next_sample = AXIS_WIDTH'(i_sample + trim_mg);
  end

  // registered corrected sample
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_sample <= '0;
    end else begin
      o_sample <= next_sample;
    end
  end

endmodule : irt_axis_trim

// [irt_host_model.sv]
`timescale 1ns/1ps
// host side of both interrupt lines, each line with a pull-up
module irt_host_model (
  input  wire logic i_pin_a_out,
  input  wire logic i_pin_a_oe,
  input  wire logic i_pin_b_out,
  input  wire logic i_pin_b_oe,
  input  wire logic i_active_high,
  output      logic o_line_a,
  output      logic o_line_b,
  output      logic o_irq_a,
  output      logic o_irq_b
);
  // a released line floats up to the pull-up level
  assign o_line_a = i_pin_a_oe ? i_pin_a_out : 1'b1;
  assign o_line_b = i_pin_b_oe ? i_pin_b_out : 1'b1;
  // host decodes an event with the polarity it configured
  assign o_irq_a = o_line_a ~^ i_active_high;
  assign o_irq_b = o_line_b ~^ i_active_high;
endmodule : irt_host_model

// [irt_interrupt_routing_offset_trim.sv]
`timescale 1ns/1ps
// Functional notes
// - four wake-select bits let transient, orientation, pulse and fall/motion wake from sleep, else bypassed in sleep; reset clear.
// - the polarity bit makes an active pin low at 0 (reset) and high at 1.
// - the drive-select bit gives push-pull at 0 (reset) and open drain at 1.
// - a source's flag reaches a pin only while its enable bit is set.
// - six enable bits at 7,5,4,3,2,0 reset to 0 with bits 6 and 1 reading zero.
// - every enabled source not bypassed in sleep reaches exactly one of the two pins.
// - a routing bit at the enable's position sends the source to pin a at 1, pin b at 0 (reset).
// - the host reads the source register at 0x0c to learn which sources fired.
// - each axis has an 8-bit two's complement trim added to its sample.
// - one trim step equals 2 mg.
// - trim registers are read/write and reset to zero.
// - x, y and z trims sit at 0x2f, 0x30 and 0x31.
module irt_interrupt_routing_offset_trim #(
  parameter int AXIS_WIDTH = irt_pkg::IRT_AXIS_WIDTH
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset_n,
  input  wire irt_pkg::irt_reg_req_s        i_reg_req,
  output      logic [7:0]                   o_reg_rdata,
  input  wire irt_pkg::irt_src_s            i_src_flags,
  input  wire logic                         i_sleep_mode,
  output      logic                         o_wake_request,
  input  wire logic signed [AXIS_WIDTH-1:0] i_x_sample,
  input  wire logic signed [AXIS_WIDTH-1:0] i_y_sample,
  input  wire logic signed [AXIS_WIDTH-1:0] i_z_sample,
  output      logic signed [AXIS_WIDTH-1:0] o_x_sample,
  output      logic signed [AXIS_WIDTH-1:0] o_y_sample,
  output      logic signed [AXIS_WIDTH-1:0] o_z_sample,
  output      logic                         o_irq_pin_a_out,
  output      logic                         o_irq_pin_a_oe,
  output      logic                         o_irq_pin_b_out,
  output      logic                         o_irq_pin_b_oe
);
  import irt_pkg::*;

  irt_src_s                         interrupt_enable_map;
  irt_src_s                         interrupt_pin_routing;
  irt_wake_pin_s                    wake_and_pin_config;
  logic [IRT_TRIM_WIDTH-1:0]        axis_trim [IRT_AXES];
  logic signed [AXIS_WIDTH-1:0]     axis_in   [IRT_AXES];
  logic signed [AXIS_WIDTH-1:0]     axis_out  [IRT_AXES];
  irt_src_s                         awake_mask;
  irt_src_s                         gated;
  logic                             active_a;
  logic                             active_b;
  logic                             next_wake;
  logic [7:0]                       next_rdata;

  // control register writes
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      interrupt_enable_map  <= IRT_RST_ENABLE;
      interrupt_pin_routing <= IRT_RST_ROUTING;
      wake_and_pin_config   <= IRT_RST_WAKE_PIN;
    end else if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        IRT_ADDR_ENABLE_MAP:  interrupt_enable_map  <= i_reg_req.wdata & IRT_SRC_MASK;
        IRT_ADDR_PIN_ROUTING: interrupt_pin_routing <= i_reg_req.wdata & IRT_SRC_MASK;
        IRT_ADDR_WAKE_PIN:    wake_and_pin_config   <= i_reg_req.wdata & IRT_WAKE_PIN_MASK;
        default: begin
        end
      endcase
    end
  end

  // trim register writes
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (int i = 0; i < IRT_AXES; i++) begin
        axis_trim[i] <= IRT_RST_TRIM;
      end
    end else if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        IRT_ADDR_X_TRIM: axis_trim[0] <= i_reg_req.wdata;
        IRT_ADDR_Y_TRIM: axis_trim[1] <= i_reg_req.wdata;
        IRT_ADDR_Z_TRIM: axis_trim[2] <= i_reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    case (i_reg_req.addr)
      IRT_ADDR_SOURCE:      next_rdata = i_src_flags & IRT_SRC_MASK;
      IRT_ADDR_WAKE_PIN:    next_rdata = wake_and_pin_config;
      IRT_ADDR_ENABLE_MAP:  next_rdata = interrupt_enable_map;
      IRT_ADDR_PIN_ROUTING: next_rdata = interrupt_pin_routing;
      IRT_ADDR_X_TRIM:      next_rdata = axis_trim[0];
      IRT_ADDR_Y_TRIM:      next_rdata = axis_trim[1];
      IRT_ADDR_Z_TRIM:      next_rdata = axis_trim[2];
      default:              next_rdata = 8'h00;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  // wake-capable sources without their wake bit set are bypassed while asleep
  always_comb begin
    awake_mask              = IRT_SRC_MASK;
    awake_mask.transient    = !i_sleep_mode || wake_and_pin_config.wake_on_transient;
    awake_mask.orientation  = !i_sleep_mode || wake_and_pin_config.wake_on_orientation;
    awake_mask.pulse        = !i_sleep_mode || wake_and_pin_config.wake_on_pulse;
    awake_mask.fall_motion  = !i_sleep_mode || wake_and_pin_config.wake_on_fall_motion;
    gated    = i_src_flags & interrupt_enable_map & awake_mask;
    active_a = |(gated & interrupt_pin_routing);
    active_b = |(gated & ~interrupt_pin_routing);
    // only the four wake-capable functions raise a wake request
    next_wake = i_sleep_mode && (gated.transient || gated.orientation
                                 || gated.pulse || gated.fall_motion);
  end

  // pin level and enable from polarity and drive style
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_irq_pin_a_out <= 1'b1;
      o_irq_pin_a_oe  <= 1'b1;
      o_irq_pin_b_out <= 1'b1;
      o_irq_pin_b_oe  <= 1'b1;
    end else begin
      o_irq_pin_a_out <= active_a ~^ wake_and_pin_config.irq_polarity;
      o_irq_pin_b_out <= active_b ~^ wake_and_pin_config.irq_polarity;
      // open drain only ever pulls low
      o_irq_pin_a_oe  <= (wake_and_pin_config.irq_drive_select == IRT_DRIVE_PUSH_PULL)
                         || (active_a ~^ wake_and_pin_config.irq_polarity) == 1'b0;
      o_irq_pin_b_oe  <= (wake_and_pin_config.irq_drive_select == IRT_DRIVE_PUSH_PULL)
                         || (active_b ~^ wake_and_pin_config.irq_polarity) == 1'b0;
    end
  end

  // wake request from a wake-capable source while asleep
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_wake_request <= 1'b0;
    end else begin
      o_wake_request <= next_wake;
    end
  end

  // per-axis trim
  assign axis_in[0] = i_x_sample;
  assign axis_in[1] = i_y_sample;
  assign axis_in[2] = i_z_sample;
  assign o_x_sample = axis_out[0];
  assign o_y_sample = axis_out[1];
  assign o_z_sample = axis_out[2];

  for (genvar g = 0; g < IRT_AXES; g++) begin : g_axis
    irt_axis_trim #(
      .AXIS_WIDTH (AXIS_WIDTH),
      .TRIM_WIDTH (IRT_TRIM_WIDTH),
      .STEP_MG    (IRT_TRIM_STEP_MG)
    ) u_trim (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_sample  (axis_in[g]),
      .i_trim    (axis_trim[g]),
      .o_sample  (axis_out[g])
    );
  end

  // a pin signals active level per polarity one cycle after the flag
  sequence s_a_flagged;
    active_a;
  endsequence
  sequence s_a_level;
    o_irq_pin_a_out == $past(wake_and_pin_config.irq_polarity);
  endsequence

  // registered pins use the polarity of the cycle before
  AST_PIN_A_ACTIVE: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    s_a_flagged |=> s_a_level)
    else $error("pin a not active after routed flag");

  AST_PIN_B_IDLE: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    !active_b |=> o_irq_pin_b_out != $past(wake_and_pin_config.irq_polarity))
    else $error("pin b active with no routed flag");

  AST_ONE_PIN: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $onehot(gated) |=> (o_irq_pin_a_out == $past(wake_and_pin_config.irq_polarity))
      != (o_irq_pin_b_out == $past(wake_and_pin_config.irq_polarity)))
    else $error("enabled source not on exactly one pin");

  AST_ROUTE_B: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    (|(gated & ~interrupt_pin_routing))
      |=> o_irq_pin_b_out == $past(wake_and_pin_config.irq_polarity))
    else $error("routing bit clear did not select pin b");

  AST_DISABLED_SILENT: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    interrupt_enable_map == 8'h00
      |=> o_irq_pin_a_out != $past(wake_and_pin_config.irq_polarity)
      && o_irq_pin_b_out != $past(wake_and_pin_config.irq_polarity))
    else $error("pin driven with all sources disabled");

  AST_RESERVED_ZERO: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    interrupt_enable_map.rsv6 == 1'b0 && interrupt_enable_map.rsv1 == 1'b0
      && interrupt_pin_routing.rsv6 == 1'b0 && interrupt_pin_routing.rsv1 == 1'b0)
    else $error("reserved enable or routing bit set");

  AST_OPEN_DRAIN_RELEASE: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_irq_pin_a_oe && wake_and_pin_config.irq_drive_select && $stable(wake_and_pin_config)
      |-> o_irq_pin_a_out == 1'b0)
    else $error("open drain pin driven high");

  AST_SLEEP_BYPASS: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    i_sleep_mode && !wake_and_pin_config.wake_on_pulse |-> !gated.pulse)
    else $error("bypassed pulse source passed in sleep");

  AST_TRIM_WRITE: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    i_reg_req.wr && i_reg_req.addr == IRT_ADDR_Y_TRIM |=> axis_trim[1] == $past(i_reg_req.wdata))
    else $error("y trim write lost");

  AST_SOURCE_READ: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    i_reg_req.rd && i_reg_req.addr == IRT_ADDR_SOURCE
      |=> o_reg_rdata == ($past(i_src_flags) & IRT_SRC_MASK))
    else $error("source register read wrong");

endmodule : irt_interrupt_routing_offset_trim

// [irt_pkg.sv]
package irt_pkg;

  // register map, byte addresses on the register port
  localparam logic [7:0] IRT_ADDR_SOURCE      = 8'h0c;
  localparam logic [7:0] IRT_ADDR_WAKE_PIN    = 8'h2c;
  localparam logic [7:0] IRT_ADDR_ENABLE_MAP  = 8'h2d;
  localparam logic [7:0] IRT_ADDR_PIN_ROUTING = 8'h2e;
  localparam logic [7:0] IRT_ADDR_X_TRIM      = 8'h2f;
  localparam logic [7:0] IRT_ADDR_Y_TRIM      = 8'h30;
  localparam logic [7:0] IRT_ADDR_Z_TRIM      = 8'h31;

  // writable bit masks, reserved bits read as zero
  localparam logic [7:0] IRT_SRC_MASK      = 8'hbd;
  localparam logic [7:0] IRT_WAKE_PIN_MASK = 8'h7b;

  // reset values
  localparam logic [7:0] IRT_RST_ENABLE   = 8'h00;
  localparam logic [7:0] IRT_RST_ROUTING  = 8'h00;
  localparam logic [7:0] IRT_RST_WAKE_PIN = 8'h00;
  localparam logic [7:0] IRT_RST_TRIM     = 8'h00;

  // pin polarity and drive encodings
  localparam logic IRT_POL_ACTIVE_LOW  = 1'b0;
  localparam logic IRT_DRIVE_PUSH_PULL = 1'b0;
  localparam logic IRT_ROUTE_PIN_B     = 1'b0;

  // trim step in mg per least-significant bit
  localparam int IRT_TRIM_STEP_MG = 2;
  localparam int IRT_TRIM_WIDTH   = 8;
  localparam int IRT_AXIS_WIDTH   = 16;
  localparam int IRT_AXES         = 3;

  // one bit per interrupt source, same layout in source, enable and routing
  typedef struct packed {
    logic sleep_wake;
    logic rsv6;
    logic transient;
    logic orientation;
    logic pulse;
    logic fall_motion;
    logic rsv1;
    logic sample_ready;
  } irt_src_s;

  // wake-from-sleep selection and pin style
  typedef struct packed {
    logic rsv7;
    logic wake_on_transient;
    logic wake_on_orientation;
    logic wake_on_pulse;
    logic wake_on_fall_motion;
    logic rsv2;
    logic irq_polarity;
    logic irq_drive_select;
  } irt_wake_pin_s;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irt_reg_req_s;

endpackage : irt_pkg
